// File: verilog/pm_pkg.sv
// Shared constants and types for the power-management control block.
// Assumes a 100 MHz core clock and host accesses decoded in system I/O space.
package pm_pkg;

   // Core clock and timer rate
   localparam int unsigned      CORE_PERIOD_NS = 10;
   localparam longint unsigned  CORE_CLK_HZ    = 64'd1000000000 / CORE_PERIOD_NS;
   localparam longint unsigned  TIMER_TICK_HZ  = 64'd3579545;
   localparam int unsigned      NCO_W          = 32;
   // Phase step per core cycle; fraction of 2^32 per tick
   localparam logic [31:0]      NCO_STEP       =
      32'((TIMER_TICK_HZ << NCO_W) / CORE_CLK_HZ);

   // Control register layout
   localparam int unsigned      CTL_W          = 16;
   localparam int unsigned      ROUTE_BIT      = 0;
   localparam int unsigned      BMWAKE_BIT     = 1;
   localparam int unsigned      LOCKREL_BIT    = 2;
   localparam int unsigned      STYPE_LSB      = 10;
   localparam int unsigned      STYPE_W        = 3;
   localparam int unsigned      STRIG_BIT      = 13;
   localparam logic [15:0]      CTL_RESET      = 16'h0000;
   // Bits the host may change by writing
   localparam logic [15:0]      CTL_WR_MASK    = 16'h1C02;
   // Bits that read back their state
   localparam logic [15:0]      CTL_RD_MASK    = 16'h1C03;
   localparam logic [15:0]      CTL_ALL_IMPL   = 16'h3C07;

   // Default I/O placement, word aligned
   localparam logic [15:0]      CTL_BASE_DEF   = 16'h0404;
   localparam logic [15:0]      TMR_BASE_DEF   = 16'h0408;
   localparam logic [3:0]       BE_DWORD       = 4'hF;
   localparam logic [31:0]      TMR_RESET      = 32'h0000_0000;

   // One host access in system I/O space
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } io_req_s;

   // Sleep sequencing towards the platform power logic
   typedef enum logic [1:0] {
      SLP_IDLE = 2'b00,
      SLP_REQ  = 2'b01,
      SLP_DONE = 2'b11
   } sleep_state_e;

endpackage

// File: verilog/pm_timer_counter.sv
// Free-running power-management timer with fractional tick generator.
// Assumes run is a level synchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
module pm_timer_counter #(
   parameter int unsigned WIDTH = 24
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             resetn,
   // Counting gate
   input  wire logic             run,
   // Count and carry
   output logic [WIDTH-1:0]      count,
   output logic                  msb_toggle
);

   logic [pm_pkg::NCO_W-1:0]     phase_r;
   logic [pm_pkg::NCO_W:0]       phase_sum;
   logic                         tick;
   logic [WIDTH-1:0]             count_nxt;

   assign phase_sum = {1'b0, phase_r} + {1'b0, pm_pkg::NCO_STEP};
   assign tick      = run & phase_sum[pm_pkg::NCO_W];
   // Wraps from all ones to zero by plain overflow
   assign count_nxt = count + WIDTH'(1);

   // Phase holds while stopped so a restart resumes mid-period
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         phase_r <= '0;
      end else if (run) begin
         phase_r <= phase_sum[pm_pkg::NCO_W-1:0];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         count <= pm_pkg::TMR_RESET[WIDTH-1:0];
      end else if (tick) begin
         count <= count_nxt;
      end
   end

   // Top implemented bit changes on every tick that flips it
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         msb_toggle <= 1'b0;
      end else begin
         msb_toggle <= tick & (count_nxt[WIDTH-1] ^ count[WIDTH-1]);
      end
   end

endmodule
`default_nettype wire

// File: verilog/pm_control_and_timer.sv
// Power-management control register and timer, host side in system I/O.
// Assumes one host access per request pulse, synchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
module pm_control_and_timer #(
   parameter logic [15:0] CTL_BASE    = pm_pkg::CTL_BASE_DEF,
   parameter logic [15:0] TMR_BASE    = pm_pkg::TMR_BASE_DEF,
   parameter logic [15:0] IMPL_MASK   = pm_pkg::CTL_ALL_IMPL,
   parameter int unsigned TIMER_WIDTH = 24
) (
   // Clock and reset
   input  wire logic            core_clk,
   input  wire logic            resetn,
   // Host system I/O access
   input  wire pm_pkg::io_req_s io_req,
   output logic [31:0]          io_rdata,
   output logic                 io_rvalid,
   // System power state
   input  wire logic            system_working,
   input  wire logic            ref_clk_running,
   // Route control from hardware
   input  wire logic            route_set,
   input  wire logic            route_clear,
   // Power events and status companions
   input  wire logic            pm_event,
   input  wire logic            timer_carry_irq_enable,
   input  wire logic            timer_carry_clear,
   input  wire logic            firmware_event_enable,
   input  wire logic            firmware_flag_clear,
   // Interrupt events, one-cycle pulses
   output logic                 system_control_irq,
   output logic                 system_mgmt_irq,
   // Visible state
   output logic                 event_route_select,
   output logic                 busmaster_wake_enable,
   output logic                 timer_carry_flag,
   output logic                 firmware_event_flag,
   output logic                 timer_width_flag,
   // Processor idle control
   input  wire logic            bm_request,
   input  wire logic            cpu_deep_idle,
   output logic                 cpu_wake,
   // Sleep entry handshake
   output logic                 sleep_req,
   output logic [2:0]           sleep_type,
   input  wire logic            sleep_ack
);

   // Elaboration checks
   // Software expects 24 or 32; narrower builds only shorten the carry
   if (TIMER_WIDTH < 8 || TIMER_WIDTH > 32) begin : g_bad_width
      $error("TIMER_WIDTH must lie between 8 and 32");
   end
   if (CTL_BASE[1:0] != 2'b00 || TMR_BASE[1:0] != 2'b00) begin : g_bad_base
      $error("register bases must be 32-bit aligned");
   end
   if (CTL_BASE[15:2] == TMR_BASE[15:2]) begin : g_bad_overlap
      $error("control and timer must not share a word");
   end

   // Merge enabled byte lanes of a write into the held value
   function automatic logic [15:0] lane_merge(
      input logic [15:0] old_v,
      input logic [15:0] new_v,
      input logic [1:0]  be
   );
      logic [15:0] res;
      res = old_v;
      if (be[0]) begin
         res[7:0] = new_v[7:0];
      end
      if (be[1]) begin
         res[15:8] = new_v[15:8];
      end
      return res;
   endfunction

   // Word-granular address match
   function automatic logic word_hit(
      input logic [15:0] addr,
      input logic [15:0] base
   );
      return addr[15:2] == base[15:2];
   endfunction

   localparam logic [15:0] WR_MASK = pm_pkg::CTL_WR_MASK & IMPL_MASK;
   localparam logic [15:0] RD_MASK = pm_pkg::CTL_RD_MASK & IMPL_MASK;

   logic                    ctl_hit;
   logic                    tmr_hit;
   logic                    ctl_wr;
   logic                    ctl_rd;
   logic                    tmr_rd;
   logic [15:0]             wr_lanes;
   logic [15:0]             ctl_view;
   logic [15:0]             ctl_merged;
   logic                    lock_rel_wr;
   logic                    sleep_trig_wr;
   logic                    bmwake_r;
   logic [2:0]              stype_r;
   logic                    route_r;
   logic [TIMER_WIDTH-1:0]  tmr_count;
   logic                    tmr_toggle;
   logic                    tmr_run;
   logic [31:0]             tmr_word;
   logic                    pm_evt;
   logic                    fw_evt;
   pm_pkg::sleep_state_e    slp_state_r;
   pm_pkg::sleep_state_e    slp_state_nxt;

   // Decode
   assign ctl_hit  = word_hit(io_req.addr, CTL_BASE);
   assign tmr_hit  = word_hit(io_req.addr, TMR_BASE);
   assign ctl_wr   = io_req.wr & ctl_hit;
   assign ctl_rd   = io_req.rd & ctl_hit;
   // Timer answers only a full dword read
   assign tmr_rd   = io_req.rd & tmr_hit
                     & (io_req.be == pm_pkg::BE_DWORD);

   // Lane mask of the current write, limited to the low word
   assign wr_lanes = {{8{io_req.be[1]}}, {8{io_req.be[0]}}};

   // Held state as it sits in the register
   always_comb begin
      ctl_view = pm_pkg::CTL_RESET;
      ctl_view[pm_pkg::ROUTE_BIT]  = route_r;
      ctl_view[pm_pkg::BMWAKE_BIT] = bmwake_r;
      ctl_view[pm_pkg::STYPE_LSB +: pm_pkg::STYPE_W] = stype_r;
   end

   assign ctl_merged = lane_merge(ctl_view, io_req.wdata[15:0],
                                  io_req.be[1:0]);

   // Strobe bits act only in lanes written and in implemented positions
   assign lock_rel_wr   = ctl_wr & wr_lanes[pm_pkg::LOCKREL_BIT]
                          & io_req.wdata[pm_pkg::LOCKREL_BIT]
                          & IMPL_MASK[pm_pkg::LOCKREL_BIT];
   assign sleep_trig_wr = ctl_wr & wr_lanes[pm_pkg::STRIG_BIT]
                          & io_req.wdata[pm_pkg::STRIG_BIT]
                          & IMPL_MASK[pm_pkg::STRIG_BIT];

   // Writable fields
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bmwake_r <= pm_pkg::CTL_RESET[pm_pkg::BMWAKE_BIT];
      end else if (ctl_wr & WR_MASK[pm_pkg::BMWAKE_BIT]) begin
         bmwake_r <= ctl_merged[pm_pkg::BMWAKE_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         stype_r <= pm_pkg::CTL_RESET[pm_pkg::STYPE_LSB +: 3];
      end else if (ctl_wr & WR_MASK[pm_pkg::STYPE_LSB]) begin
         stype_r <= ctl_merged[pm_pkg::STYPE_LSB +: pm_pkg::STYPE_W];
      end
   end

   // Host writes never touch the route bit; clear wins only alone
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         route_r <= pm_pkg::CTL_RESET[pm_pkg::ROUTE_BIT];
      end else if (IMPL_MASK[pm_pkg::ROUTE_BIT]) begin
         if (route_set) begin
            route_r <= 1'b1;
         end else if (route_clear) begin
            route_r <= 1'b0;
         end
      end
   end

   // Timer
   assign tmr_run = system_working & ref_clk_running;

   pm_timer_counter #(
      .WIDTH      (TIMER_WIDTH)
   ) u_timer (
      .core_clk   (core_clk),
      .resetn     (resetn),
      .run        (tmr_run),
      .count      (tmr_count),
      .msb_toggle (tmr_toggle)
   );

   // Upper byte is zero on a 24-bit build
   assign tmr_word = 32'(tmr_count);

   // Read answer, one cycle after any read; unmapped reads give zero
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         io_rdata <= 32'h0000_0000;
      end else if (ctl_rd) begin
         // Strobes, reserved and top bits always zero
         io_rdata <= {16'h0000, ctl_view & RD_MASK & wr_lanes};
      end else if (tmr_rd) begin
         // Same-cycle sample keeps all bytes coherent
         io_rdata <= tmr_word;
      end else if (io_req.rd) begin
         io_rdata <= 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         io_rvalid <= 1'b0;
      end else begin
         io_rvalid <= io_req.rd;
      end
   end

   // Carry flag; a toggle in the clearing cycle is kept
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         timer_carry_flag <= 1'b0;
      end else if (tmr_toggle) begin
         timer_carry_flag <= 1'b1;
      end else if (timer_carry_clear) begin
         timer_carry_flag <= 1'b0;
      end
   end

   // Firmware flag records every lock release, set beats clear
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         firmware_event_flag <= 1'b0;
      end else if (lock_rel_wr) begin
         firmware_event_flag <= 1'b1;
      end else if (firmware_flag_clear) begin
         firmware_event_flag <= 1'b0;
      end
   end

   // Event sources
   assign pm_evt = pm_event
                   | (tmr_toggle & timer_carry_irq_enable);
   assign fw_evt = lock_rel_wr & firmware_event_enable;

   // Steering; lock release always goes to firmware
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         system_control_irq <= 1'b0;
         system_mgmt_irq    <= 1'b0;
      end else begin
         system_control_irq <= pm_evt & route_r;
         system_mgmt_irq    <= (pm_evt & ~route_r) | fw_evt;
      end
   end

   // Bus-master wake of deep-idle processors
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cpu_wake <= 1'b0;
      end else begin
         cpu_wake <= bm_request & bmwake_r & cpu_deep_idle;
      end
   end

   // Sleep sequencer: request holds until acknowledged, then drops
   always_comb begin
      slp_state_nxt = slp_state_r;
      case (slp_state_r)
         pm_pkg::SLP_IDLE: begin
            if (sleep_trig_wr) begin
               slp_state_nxt = pm_pkg::SLP_REQ;
            end
         end
         pm_pkg::SLP_REQ: begin
            if (sleep_ack) begin
               slp_state_nxt = pm_pkg::SLP_DONE;
            end
         end
         pm_pkg::SLP_DONE: begin
            if (!sleep_ack) begin
               slp_state_nxt = pm_pkg::SLP_IDLE;
            end
         end
         default: begin
            slp_state_nxt = pm_pkg::SLP_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         slp_state_r <= pm_pkg::SLP_IDLE;
      end else begin
         slp_state_r <= slp_state_nxt;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sleep_req <= 1'b0;
      end else begin
         sleep_req <= (slp_state_nxt == pm_pkg::SLP_REQ);
      end
   end

   // Type latched with the trigger, taking the same write's field
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sleep_type <= 3'h0;
      end else if (sleep_trig_wr && slp_state_r == pm_pkg::SLP_IDLE) begin
         sleep_type <= WR_MASK[pm_pkg::STYPE_LSB]
                       ? ctl_merged[pm_pkg::STYPE_LSB +: pm_pkg::STYPE_W]
                       : stype_r;
      end
   end

   // Mirrors for the surrounding power logic
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         event_route_select    <= 1'b0;
         busmaster_wake_enable <= 1'b0;
         timer_width_flag      <= 1'b0;
      end else begin
         event_route_select    <= route_r;
         busmaster_wake_enable <= bmwake_r;
         timer_width_flag      <= (TIMER_WIDTH == 32);
      end
   end

endmodule
`default_nettype wire

// File: testbench/pm_control_and_timer_sva.sv
// Checker for the power control register and timer block.
// Assumes it is bound onto the top module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module pm_control_and_timer_sva #(
   parameter logic [15:0] CTL_BASE = pm_pkg::CTL_BASE_DEF
) (
   // Clock and reset
   input wire logic            core_clk,
   input wire logic            resetn,
   // Host access
   input wire pm_pkg::io_req_s io_req,
   input wire logic [31:0]     io_rdata,
   input wire logic            io_rvalid,
   // Events and state
   input wire logic            pm_event,
   input wire logic            route_set,
   input wire logic            route_clear,
   input wire logic            event_route_select,
   input wire logic            system_control_irq,
   input wire logic            system_mgmt_irq,
   input wire logic            firmware_event_enable,
   input wire logic            timer_carry_irq_enable,
   input wire logic            timer_carry_flag,
   // Wake and sleep
   input wire logic            bm_request,
   input wire logic            cpu_deep_idle,
   input wire logic            busmaster_wake_enable,
   input wire logic            cpu_wake,
   input wire logic            sleep_req,
   input wire logic [2:0]      sleep_type,
   input wire logic            sleep_ack
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   wire logic ctl_hit = io_req.addr[15:2] == CTL_BASE[15:2];
   // Route bit output lags a cycle, so two quiet cycles are needed
   sequence s_no_hw;
      (!route_set && !route_clear)[*2];
   endsequence
   sequence s_wake_cause;
      bm_request && cpu_deep_idle ##1 busmaster_wake_enable;
   endsequence
   sequence s_trig;
      io_req.wr && ctl_hit && io_req.be[1] && io_req.wdata[13]
         && !sleep_req && !sleep_ack && !$past(sleep_ack);
   endsequence
   AST_RD_ANSWER: assert property (io_req.rd |=> io_rvalid)
      else $error("read got no answer");
   AST_RD_ZERO: assert property (io_req.rd && ctl_hit |=>
      io_rdata[15:13] == 3'h0 && io_rdata[9:3] == 7'h00)
      else $error("control bits read nonzero");
   AST_ROUTE_HW: assert property (s_no_hw |=>
      $stable(event_route_select))
      else $error("route bit moved without hardware cause");
   AST_ROUTE_STEER: assert property (s_no_hw ##0 pm_event |=>
      system_control_irq == $past(event_route_select)
      && system_mgmt_irq != $past(event_route_select))
      else $error("power event steered wrongly");
   AST_WAKE: assert property (s_wake_cause |-> cpu_wake)
      else $error("bus master request did not wake");
   AST_NO_WAKE: assert property (!bm_request |=> !cpu_wake)
      else $error("wake without bus master request");
   AST_SLEEP_GO: assert property (s_trig |=> sleep_req
      && sleep_type == $past(io_req.wdata[12:10]))
      else $error("sleep trigger not taken");
   AST_SLEEP_HOLD: assert property (sleep_req && !sleep_ack |=>
      sleep_req)
      else $error("sleep request dropped early");
   AST_SLEEP_END: assert property (sleep_req && sleep_ack |->
      ##[1:2] !sleep_req)
      else $error("sleep request outlived acknowledge");
   AST_LOCK: assert property (io_req.wr && ctl_hit && io_req.be[0]
      && io_req.wdata[2] && firmware_event_enable |=> system_mgmt_irq)
      else $error("lock release raised no event");
   AST_CARRY_IRQ: assert property ($rose(timer_carry_flag)
      && $past(timer_carry_irq_enable) && event_route_select
      |-> system_control_irq)
      else $error("enabled carry raised no event");
   AST_CARRY_QUIET: assert property ($rose(timer_carry_flag)
      && !$past(timer_carry_irq_enable) && !$past(pm_event)
      |-> !system_control_irq)
      else $error("disabled carry raised an event");
endmodule
bind pm_control_and_timer pm_control_and_timer_sva #(
   .CTL_BASE(CTL_BASE)
) u_sva (
   .core_clk, .resetn, .io_req, .io_rdata, .io_rvalid, .pm_event,
   .route_set, .route_clear, .event_route_select, .system_control_irq,
   .system_mgmt_irq, .firmware_event_enable, .timer_carry_irq_enable,
   .timer_carry_flag, .bm_request, .cpu_deep_idle, .busmaster_wake_enable,
   .cpu_wake, .sleep_req, .sleep_type, .sleep_ack
);
`default_nettype wire

// File: testbench/pm_host_model.sv
// Host software model issuing system I/O reads and writes.
// Assumes the bench calls its tasks; inputs change at falling edges.
`timescale 1ns/1ns
`default_nettype none
module pm_host_model #(
   parameter logic [15:0] CTL_BASE = pm_pkg::CTL_BASE_DEF
) (
   // Clock
   input  wire logic            core_clk,
   // Host access
   output var pm_pkg::io_req_s  io_req,
   input  wire logic [31:0]     io_rdata,
   input  wire logic            io_rvalid,
   // Route bit as software sees it
   input  wire logic            event_route_select
);
   initial io_req = '0;
   // Released lines invert, so a stale value can never match
   task automatic release_bus();
      io_req.rd    = 1'b0;
      io_req.wr    = 1'b0;
      io_req.addr  = ~io_req.addr;
      io_req.wdata = ~io_req.wdata;
   endtask
   task automatic wr(input logic [15:0] a, input logic [3:0] be,
                     input logic [31:0] d);
      logic [31:0] v;
      v = d;
      if (a[15:2] == CTL_BASE[15:2]) begin
         v[0]   = event_route_select;
         v[8:3] = 6'h00;
      end
      @(negedge core_clk);
      io_req.addr  = a;
      io_req.be    = be;
      io_req.wdata = v;
      io_req.wr    = 1'b1;
      @(posedge core_clk);
      @(negedge core_clk);
      release_bus();
   endtask
   task automatic rd(input logic [15:0] a, input logic [3:0] be,
                     output logic [31:0] q);
      @(negedge core_clk);
      io_req.addr = a;
      io_req.be   = be;
      io_req.rd   = 1'b1;
      @(posedge core_clk);
      @(negedge core_clk);
      release_bus();
      q = (io_rvalid === 1'b1) ? io_rdata : 32'hFFFF_FFFF;
   endtask
endmodule
`default_nettype wire

// File: testbench/pm_control_and_timer_tb.sv
// Self-checking bench for the power control register and timer.
// Assumes the host model drives I/O; the bench drives the other inputs.
`timescale 1ns/1ns
`default_nettype none
module pm_control_and_timer_tb;
   localparam logic [15:0] CB = pm_pkg::CTL_BASE_DEF;
   localparam logic [15:0] TB = pm_pkg::TMR_BASE_DEF;
   logic core_clk = 1'b0, resetn = 1'b0;
   pm_pkg::io_req_s io_req;
   logic [31:0] io_rdata, q, q2;
   logic [7:0]  d;
   logic io_rvalid, system_control_irq, system_mgmt_irq, cpu_wake;
   logic event_route_select, busmaster_wake_enable, timer_carry_flag;
   logic firmware_event_flag, timer_width_flag, sleep_req;
   logic [2:0] sleep_type;
   logic system_working = 0, ref_clk_running = 0, route_set = 0;
   logic route_clear = 0, pm_event = 0, timer_carry_irq_enable = 0;
   logic timer_carry_clear = 0, firmware_event_enable = 0;
   logic firmware_flag_clear = 0, bm_request = 0, cpu_deep_idle = 0;
   logic sleep_ack = 0;
   int failures = 0, compares = 0, irqs;
   // Short timer so the carry shows within a few thousand cycles
   pm_control_and_timer #(.TIMER_WIDTH(8)) DUT (
      .core_clk, .resetn, .io_req, .io_rdata, .io_rvalid, .system_working,
      .ref_clk_running, .route_set, .route_clear, .pm_event,
      .timer_carry_irq_enable, .timer_carry_clear, .firmware_event_enable,
      .firmware_flag_clear, .system_control_irq, .system_mgmt_irq,
      .event_route_select, .busmaster_wake_enable, .timer_carry_flag,
      .firmware_event_flag, .timer_width_flag, .bm_request, .cpu_deep_idle,
      .cpu_wake, .sleep_req, .sleep_type, .sleep_ack
   );
   pm_host_model host (
      .core_clk, .io_req, .io_rdata, .io_rvalid, .event_route_select
   );
   always #5 core_clk = ~core_clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic print_verdict();
      if (failures == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      print_verdict();
   end
   initial begin
      cyc(20);
      resetn = 1'b1;
      host.rd(CB, 4'h3, q);
      chk(q, 32'h0000_0000);
      chk(timer_width_flag, 1'b0);
      host.wr(CB, 4'h3, 32'h0000_2402);
      chk(sleep_req, 1'b1);
      chk(sleep_type, 3'h1);
      cyc(1);
      chk(busmaster_wake_enable, 1'b1);
      sleep_ack = 1'b1;
      cyc(2);
      chk(sleep_req, 1'b0);
      sleep_ack = 1'b0;
      cyc(2);
      host.rd(CB, 4'h3, q);
      chk(q, 32'h0000_0402);
      host.wr(CB, 4'h2, 32'h0000_1800);
      chk(sleep_req, 1'b0);
      host.rd(CB, 4'h3, q);
      chk(q, 32'h0000_1802);
      host.rd(CB, 4'h1, q);
      chk(q, 32'h0000_0002);
      host.wr(CB, 4'h3, 32'h0000_DFFF);
      chk(system_mgmt_irq, 1'b0);
      host.rd(CB, 4'h3, q);
      chk(q, 32'h0000_1C02);
      host.rd(16'h0500, 4'hF, q);
      chk(q, 32'h0000_0000);
      host.wr(TB, 4'hF, 32'hFFFF_FFFF);
      host.rd(TB, 4'hF, q);
      chk(q, 32'h0000_0000);
      firmware_event_enable = 1'b1;
      host.wr(CB, 4'h1, 32'h0000_0006);
      chk(system_mgmt_irq, 1'b1);
      cyc(1);
      chk(system_mgmt_irq, 1'b0);
      chk(firmware_event_flag, 1'b1);
      host.rd(CB, 4'h3, q);
      chk(q, 32'h0000_1C02);
      firmware_flag_clear = 1'b1;
      cyc(1);
      firmware_flag_clear = 1'b0;
      cyc(1);
      chk(firmware_event_flag, 1'b0);
      for (int k = 0; k < 2; k++) begin
         route_set = k[0];
         route_clear = !k[0];
         cyc(1);
         route_set = 1'b0;
         route_clear = 1'b0;
         cyc(2);
         pm_event = 1'b1;
         cyc(1);
         pm_event = 1'b0;
         chk(system_control_irq, k[0]);
         chk(system_mgmt_irq, !k[0]);
         host.rd(CB, 4'h3, q);
         chk(q[0], k[0]);
      end
      bm_request = 1'b1;
      cpu_deep_idle = 1'b1;
      cyc(2);
      chk(cpu_wake, 1'b1);
      host.wr(CB, 4'h1, 32'h0000_0000);
      cyc(2);
      chk(cpu_wake, 1'b0);
      bm_request = 1'b0;
      system_working = 1'b1;
      ref_clk_running = 1'b1;
      host.rd(TB, 4'hF, q);
      cyc(279);
      host.rd(TB, 4'hF, q2);
      d = q2[7:0] - q[7:0];
      chk(d inside {8'h0A, 8'h0B}, 1'b1);
      chk(q2[31:8], 32'h0000_0000);
      for (int k = 0; k < 2; k++) begin
         system_working = k[0];
         ref_clk_running = !k[0];
         host.rd(TB, 4'hF, q);
         cyc(100);
         host.rd(TB, 4'hF, q2);
         chk(q2, q);
      end
      ref_clk_running = 1'b1;
      timer_carry_irq_enable = 1'b1;
      for (int i = 0; i < 4000 && timer_carry_flag !== 1'b1; i++)
         cyc(1);
      chk(timer_carry_flag, 1'b1);
      timer_carry_clear = 1'b1;
      cyc(1);
      timer_carry_clear = 1'b0;
      timer_carry_irq_enable = 1'b0;
      cyc(1);
      chk(timer_carry_flag, 1'b0);
      irqs = 0;
      for (int i = 0; i < 4000 && timer_carry_flag !== 1'b1; i++) begin
         cyc(1);
         irqs += int'(system_control_irq === 1'b1);
      end
      chk(timer_carry_flag, 1'b1);
      chk(irqs, 32'h0000_0000);
      print_verdict();
   end
endmodule
`default_nettype wire
